// ---- pkg/mae_pkg.sv ----
package mae_pkg;

  // ******************************************************************
  // Widths and counts
  // ******************************************************************
  localparam int CODE_W     = 72;
  localparam int NUM_TMR    = 21;
  localparam int NUM_DI     = 8;
  localparam int NUM_RTD    = 3;
  localparam int NUM_PAIR   = 3;
  localparam int DLY_W      = 16;
  localparam int PCT_W      = 8;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int NUM_WORDS  = 3;
  localparam int WORD_BYTES = 4;
  localparam int WORD_SHIFT = 2;

  // ******************************************************************
  // Alarm and fault numbers
  // ******************************************************************
  localparam int C_MOTOR_OL  = 2;
  localparam int C_PTC       = 5;
  localparam int C_RTD_BASE  = 6;
  localparam int C_ROT_ABC   = 10;
  localparam int C_ROT_CBA   = 11;
  localparam int C_FREQ_LO   = 12;
  localparam int C_FREQ_HI   = 13;
  localparam int C_NOT_1PH   = 14;
  localparam int C_NOT_3PH   = 15;
  localparam int C_LINE_LO   = 21;
  localparam int C_LINE_HI   = 24;
  localparam int C_PH_LOSS   = 27;
  localparam int C_NO_LINE   = 28;
  localparam int C_RIDE_TMO  = 29;
  localparam int C_OVER_CUR  = 31;
  localparam int C_UNDER_CUR = 34;
  localparam int C_PF_LEAD   = 35;
  localparam int C_PF_LAG    = 36;
  localparam int C_IMBAL     = 37;
  localparam int C_GROUND    = 38;
  localparam int C_STACK_OL  = 47;
  localparam int C_TACH      = 53;
  localparam int C_DI_BASE   = 60;
  localparam int C_ANALOG    = 71;

  // Code served by each delay timer; the discrete inputs take the tail.
  localparam int TMR_DI_BASE = 13;
  localparam int TMR_CODE [NUM_TMR] = '{
    C_PTC, C_FREQ_LO, C_FREQ_HI, C_PH_LOSS, C_RIDE_TMO, C_OVER_CUR,
    C_UNDER_CUR, C_PF_LEAD, C_PF_LAG, C_IMBAL, C_GROUND, C_TACH, C_ANALOG,
    C_DI_BASE, C_DI_BASE + 1, C_DI_BASE + 2, C_DI_BASE + 3,
    C_DI_BASE + 4, C_DI_BASE + 5, C_DI_BASE + 6, C_DI_BASE + 7};

  // ******************************************************************
  // Levels, register map and reset values
  // ******************************************************************
  localparam logic [PCT_W-1:0] OL_TRIP_PCT  = 8'h64;
  localparam logic [PCT_W-1:0] STACK_OL_PCT = 8'h69;

  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_OL_LVL = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_ALARM0 = 8'h10;
  localparam logic [ADDR_W-1:0] REG_FAULT0 = 8'h20;
  localparam logic [ADDR_W-1:0] REG_DELAY0 = 8'h40;

  localparam int CTRL_CBA_BIT = 0;
  localparam int CTRL_3PH_BIT = 1;
  localparam int CTRL_DI_LSB  = 8;
  localparam int STAT_ALM_BIT = 0;
  localparam int STAT_FLT_BIT = 1;

  localparam logic [PCT_W-1:0] OL_LVL_RST = 8'h5A;
  localparam logic [DLY_W-1:0] DELAY_RST  = 16'h03E8;

  localparam logic [CODE_W-1:0] ONE_CODE = {{(CODE_W-1){1'b0}}, 1'b1};
  localparam logic [CODE_W-1:0] START_MASK =
    (ONE_CODE << C_ROT_ABC) | (ONE_CODE << C_ROT_CBA) |
    (ONE_CODE << C_NOT_1PH) | (ONE_CODE << C_NOT_3PH) |
    ({{(CODE_W-6){1'b0}}, 6'h3F} << C_LINE_LO);

  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // ******************************************************************
  // Types
  // ******************************************************************
  typedef enum logic [2:0] {
    TMR_IDLE = 3'b001,
    TMR_RUN  = 3'b010,
    TMR_DONE = 3'b100
  } mae_tmr_state_t;

  typedef struct packed {
    logic                running;
    logic                line_present;
    logic                rot_abc_seen;
    logic                rot_cba_seen;
    logic                single_phase_seen;
    logic [NUM_PAIR-1:0] line_low;
    logic [NUM_PAIR-1:0] line_high;
    logic                freq_low;
    logic                freq_high;
    logic                phase_loss;
    logic                sync_needed;
    logic                ride_wait;
    logic                over_cur;
    logic                under_cur;
    logic                pf_lead;
    logic                pf_lag;
    logic                imbalance;
    logic                ground_cur;
    logic                ptc_hot;
    logic [NUM_RTD-1:0]  rtd_alarm;
    logic                tach_invalid;
    logic                analog_over;
  } mae_cond_t;

endpackage

// ---- design/mae_fault_timer.sv ----
`timescale 1ns/1ns
module mae_fault_timer
  import mae_pkg::*;
(
  input  wire logic             clock_in,
  input  wire logic             arst_n_in,
  input  wire logic             cond_in,
  input  wire logic             tick_in,
  input  wire logic [DLY_W-1:0] delay_in,
  output logic                  alarm_out,
  output logic                  expire_out
);

  mae_tmr_state_t   state_r;
  mae_tmr_state_t   state_nxt;
  logic [DLY_W-1:0] cnt_r;
  logic [DLY_W-1:0] cnt_nxt;
  logic             expire_r;
  logic             expire_nxt;

  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    expire_nxt = 1'b0;
    case (state_r)
      TMR_IDLE: begin
        if (cond_in) begin
          state_nxt = TMR_RUN;
          cnt_nxt   = '0;
        end
      end
      TMR_RUN: begin
        if (!cond_in) begin
          state_nxt = TMR_IDLE;
        end else if (cnt_r >= delay_in) begin
          state_nxt  = TMR_DONE;
          expire_nxt = 1'b1;
        end else if (tick_in) begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      TMR_DONE: begin
        // The fault is raised once; the condition must drop to rearm.
        if (!cond_in) begin
          state_nxt = TMR_IDLE;
        end
      end
      default: begin
        state_nxt = TMR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r  <= TMR_IDLE;
      cnt_r    <= '0;
      expire_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      expire_r <= expire_nxt;
    end
  end

  assign alarm_out  = (state_r == TMR_RUN);
  assign expire_out = expire_r;

endmodule

// ---- design/mae_alarm_top.sv ----
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ns
// Function
// - Alarm number equals its fault number
// - Overload alarm at level, held until reset
// - Thermistor alarm before its trip delay
// - One alarm per temperature sensor group
// - Stopped rotation alarm, start makes fault
// - Frequency alarm until in range or delay
// - Stopped phase-mode alarm, start makes fault
// - Stopped line-pair voltage alarms, start faults
// - Running phase loss alarm, then fault
// - Running current alarms escalate after delay
// - Running power factor alarms escalate
// - Imbalance and ground alarms escalate
// - No-line alarm while synchronisation needed
// - Ride-through alarm, fault after delay
// - Stack alarm above threshold percentage
// - Tachometer loss alarm, fault after delay
// - Discrete input alarms escalate per timer
// - Analog level alarm escalates after delay
module mae_alarm_top
  import mae_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)
(
  input  wire logic              clock_in,
  input  wire logic              arst_n_in,
  input  wire mae_cond_t         cond_in,
  input  wire logic [PCT_W-1:0]  motor_thermal_pct_in,
  input  wire logic [PCT_W-1:0]  stack_thermal_pct_in,
  input  wire logic              ol_lockout_reset_in,
  input  wire logic              start_cmd_in,
  input  wire logic [NUM_DI-1:0] discrete_input_line_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic [DATA_W-1:0]      reg_rdata_out,
  output logic [CODE_W-1:0]      alarm_vec_out,
  output logic [CODE_W-1:0]      fault_vec_out,
  output logic                   alarm_any_out,
  output logic                   fault_any_out
);

  localparam int TICK_W = $clog2(TICK_CYC + 1);
  localparam int PAD_W  = NUM_WORDS * DATA_W;

  // ******************************************************************
  // Decode helpers
  // ******************************************************************
  function automatic logic in_bank(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] base,
                                   input int                n);
    in_bank = (a >= base) && (a < base + ADDR_W'(n * WORD_BYTES)) &&
              (a[WORD_SHIFT-1:0] == '0);
  endfunction

  function automatic int bank_idx(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] base);
    bank_idx = int'((a - base) >> WORD_SHIFT);
  endfunction

  function automatic logic [DATA_W-1:0] word_sel(input logic [CODE_W-1:0] v,
                                                 input int                w);
    logic [PAD_W-1:0] pad;
    pad      = {{(PAD_W-CODE_W){1'b0}}, v};
    word_sel = pad[w*DATA_W +: DATA_W];
  endfunction

  // ******************************************************************
  // Discrete input synchroniser
  // ******************************************************************
  logic [NUM_DI-1:0] di_meta_r;
  logic [NUM_DI-1:0] di_sync_r;

  // The pins are asynchronous to the system clock; only the second stage
  // is looked at.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      di_meta_r <= '0;
      di_sync_r <= '0;
    end else begin
      di_meta_r <= discrete_input_line_in;
      di_sync_r <= di_meta_r;
    end
  end

  // ******************************************************************
  // Delay time base
  // ******************************************************************
  logic [TICK_W-1:0] tick_cnt_r;
  logic [TICK_W-1:0] tick_cnt_nxt;
  logic              tick_r;
  logic              tick_nxt;

  // All fault delays count in these ticks, so one divider serves every
  // timer at the cost of up to one tick of jitter on the first count.
  always_comb begin
    tick_nxt     = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 1'b1;
    if (tick_cnt_r == TICK_W'(TICK_CYC - 1)) begin
      tick_cnt_nxt = '0;
      tick_nxt     = 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
    end
  end

  // ******************************************************************
  // Configuration registers
  // ******************************************************************
  logic              cba_r;
  logic              cba_nxt;
  logic              three_ph_r;
  logic              three_ph_nxt;
  logic [NUM_DI-1:0] di_en_r;
  logic [NUM_DI-1:0] di_en_nxt;
  logic [PCT_W-1:0]  overload_alarm_threshold_r;
  logic [PCT_W-1:0]  overload_alarm_threshold_nxt;
  logic [DLY_W-1:0]  delay_r   [NUM_TMR];
  logic [DLY_W-1:0]  delay_nxt [NUM_TMR];

  always_comb begin
    cba_nxt                      = cba_r;
    three_ph_nxt                 = three_ph_r;
    di_en_nxt                    = di_en_r;
    overload_alarm_threshold_nxt = overload_alarm_threshold_r;
    if (reg_wr_in && reg_addr_in == REG_CTRL) begin
      cba_nxt      = reg_wdata_in[CTRL_CBA_BIT];
      three_ph_nxt = reg_wdata_in[CTRL_3PH_BIT];
      di_en_nxt    = reg_wdata_in[CTRL_DI_LSB +: NUM_DI];
    end
    if (reg_wr_in && reg_addr_in == REG_OL_LVL) begin
      overload_alarm_threshold_nxt = reg_wdata_in[PCT_W-1:0];
    end
    for (int i = 0; i < NUM_TMR; i++) begin
      delay_nxt[i] = delay_r[i];
      if (reg_wr_in && in_bank(reg_addr_in, REG_DELAY0, NUM_TMR) &&
          bank_idx(reg_addr_in, REG_DELAY0) == i) begin
        delay_nxt[i] = reg_wdata_in[DLY_W-1:0];
      end
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cba_r                      <= 1'b0;
      three_ph_r                 <= 1'b0;
      di_en_r                    <= '0;
      overload_alarm_threshold_r <= OL_LVL_RST;
      for (int i = 0; i < NUM_TMR; i++) begin
        delay_r[i] <= DELAY_RST;
      end
    end else begin
      cba_r                      <= cba_nxt;
      three_ph_r                 <= three_ph_nxt;
      di_en_r                    <= di_en_nxt;
      overload_alarm_threshold_r <= overload_alarm_threshold_nxt;
      for (int i = 0; i < NUM_TMR; i++) begin
        delay_r[i] <= delay_nxt[i];
      end
    end
  end

  // ******************************************************************
  // Conditions by code and delay timers
  // ******************************************************************
  logic [CODE_W-1:0]  cond_code;
  logic [NUM_TMR-1:0] tmr_alarm;
  logic [NUM_TMR-1:0] tmr_exp;
  logic               stopped;

  assign stopped = !cond_in.running;

  always_comb begin
    cond_code = '0;
    cond_code[C_PTC]       = cond_in.ptc_hot;
    cond_code[C_FREQ_LO]   = cond_in.freq_low;
    cond_code[C_FREQ_HI]   = cond_in.freq_high;
    cond_code[C_PH_LOSS]   = cond_in.running && cond_in.phase_loss;
    cond_code[C_RIDE_TMO]  = cond_in.ride_wait;
    cond_code[C_OVER_CUR]  = cond_in.running && cond_in.over_cur;
    cond_code[C_UNDER_CUR] = cond_in.running && cond_in.under_cur;
    cond_code[C_PF_LEAD]   = cond_in.running && cond_in.pf_lead;
    cond_code[C_PF_LAG]    = cond_in.running && cond_in.pf_lag;
    cond_code[C_IMBAL]     = cond_in.running && cond_in.imbalance;
    cond_code[C_GROUND]    = cond_in.running && cond_in.ground_cur;
    cond_code[C_TACH]      = cond_in.tach_invalid;
    cond_code[C_ANALOG]    = cond_in.analog_over;
    cond_code[C_DI_BASE +: NUM_DI] = di_en_r & di_sync_r;
  end

  for (genvar g = 0; g < NUM_TMR; g++) begin : g_tmr
    mae_fault_timer u_tmr (
      .clock_in   (clock_in),
      .arst_n_in  (arst_n_in),
      .cond_in    (cond_code[TMR_CODE[g]]),
      .tick_in    (tick_r),
      .delay_in   (delay_r[g]),
      .alarm_out  (tmr_alarm[g]),
      .expire_out (tmr_exp[g])
    );
  end

  // ******************************************************************
  // Alarm and fault flags
  // ******************************************************************
  logic [CODE_W-1:0] alarm_r;
  logic [CODE_W-1:0] alarm_nxt;
  logic [CODE_W-1:0] fault_r;
  logic [CODE_W-1:0] fault_nxt;
  logic [CODE_W-1:0] fault_set;
  logic [PAD_W-1:0]  fault_clr;

  always_comb begin
    alarm_nxt = '0;
    fault_set = '0;
    fault_clr = '0;
    for (int i = 0; i < NUM_TMR; i++) begin
      alarm_nxt[TMR_CODE[i]] = tmr_alarm[i];
      fault_set[TMR_CODE[i]] = tmr_exp[i];
    end
    alarm_nxt[C_MOTOR_OL] = (alarm_r[C_MOTOR_OL] && !ol_lockout_reset_in) ||
                            (motor_thermal_pct_in >= overload_alarm_threshold_r);
    fault_set[C_MOTOR_OL] = (motor_thermal_pct_in >= OL_TRIP_PCT);
    alarm_nxt[C_RTD_BASE +: NUM_RTD] = cond_in.rtd_alarm;
    alarm_nxt[C_ROT_ABC] = stopped && cond_in.line_present &&
                           !cba_r && !cond_in.rot_abc_seen;
    alarm_nxt[C_ROT_CBA] = stopped && cond_in.line_present &&
                           cba_r && !cond_in.rot_cba_seen;
    alarm_nxt[C_NOT_1PH] = stopped && cond_in.line_present &&
                           !three_ph_r && !cond_in.single_phase_seen;
    alarm_nxt[C_NOT_3PH] = stopped && cond_in.line_present &&
                           three_ph_r && cond_in.single_phase_seen;
    alarm_nxt[C_LINE_LO +: NUM_PAIR] = stopped ? cond_in.line_low : '0;
    alarm_nxt[C_LINE_HI +: NUM_PAIR] = stopped ? cond_in.line_high : '0;
    alarm_nxt[C_NO_LINE] = cond_in.sync_needed && !cond_in.line_present;
    alarm_nxt[C_STACK_OL] = (stack_thermal_pct_in > STACK_OL_PCT);
    if (start_cmd_in) begin
      fault_set = fault_set | (alarm_r & START_MASK);
    end
    // Software clears faults by writing ones; a new set in the same
    // cycle wins so no trip is ever lost.
    if (reg_wr_in && in_bank(reg_addr_in, REG_FAULT0, NUM_WORDS)) begin
      fault_clr[bank_idx(reg_addr_in, REG_FAULT0)*DATA_W +: DATA_W] = reg_wdata_in;
    end
    fault_nxt = (fault_r & ~fault_clr[CODE_W-1:0]) | fault_set;
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      alarm_r <= '0;
      fault_r <= '0;
    end else begin
      alarm_r <= alarm_nxt;
      fault_r <= fault_nxt;
    end
  end

  assign alarm_vec_out = alarm_r;
  assign fault_vec_out = fault_r;
  assign alarm_any_out = |alarm_r;
  assign fault_any_out = |fault_r;

  // ******************************************************************
  // Register read port
  // ******************************************************************
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // Read data stands only in the cycle after the strobe; unmapped
  // addresses read as zero.
  always_comb begin
    rdata_nxt = '0;
    if (reg_rd_in) begin
      if (reg_addr_in == REG_CTRL) begin
        rdata_nxt[CTRL_CBA_BIT]           = cba_r;
        rdata_nxt[CTRL_3PH_BIT]           = three_ph_r;
        rdata_nxt[CTRL_DI_LSB +: NUM_DI]  = di_en_r;
      end else if (reg_addr_in == REG_OL_LVL) begin
        rdata_nxt[PCT_W-1:0] = overload_alarm_threshold_r;
      end else if (reg_addr_in == REG_STATUS) begin
        rdata_nxt[STAT_ALM_BIT] = |alarm_r;
        rdata_nxt[STAT_FLT_BIT] = |fault_r;
      end else if (in_bank(reg_addr_in, REG_ALARM0, NUM_WORDS)) begin
        rdata_nxt = word_sel(alarm_r, bank_idx(reg_addr_in, REG_ALARM0));
      end else if (in_bank(reg_addr_in, REG_FAULT0, NUM_WORDS)) begin
        rdata_nxt = word_sel(fault_r, bank_idx(reg_addr_in, REG_FAULT0));
      end else if (in_bank(reg_addr_in, REG_DELAY0, NUM_TMR)) begin
        rdata_nxt[DLY_W-1:0] = delay_r[bank_idx(reg_addr_in, REG_DELAY0)];
      end
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  ol_alarm_hold_a: assert property (
    alarm_r[C_MOTOR_OL] && !ol_lockout_reset_in |=> alarm_r[C_MOTOR_OL])
    else $error("Overload alarm dropped without lockout reset.");

  ol_trip_fault_a: assert property (
    motor_thermal_pct_in >= OL_TRIP_PCT |=> fault_r[C_MOTOR_OL])
    else $error("Overload trip did not raise its fault.");

  rtd_group_a: assert property (
    cond_in.rtd_alarm != '0 |=> alarm_r[C_RTD_BASE +: NUM_RTD] == $past(cond_in.rtd_alarm))
    else $error("Sensor group alarm missing.");

  rot_start_fault_a: assert property (
    start_cmd_in && alarm_r[C_ROT_ABC] |=> fault_r[C_ROT_ABC])
    else $error("Start with rotation alarm gave no fault.");

  line_pair_run_a: assert property (
    cond_in.running |=> alarm_r[C_LINE_LO +: 2*NUM_PAIR] == '0)
    else $error("Line voltage alarm while running.");

  ph_loss_order_a: assert property (
    $rose(fault_r[C_PH_LOSS]) |-> $past(alarm_r[C_PH_LOSS]))
    else $error("Phase loss fault without prior alarm.");

  over_cur_gate_a: assert property (
    !cond_in.running |-> ##2 !alarm_r[C_OVER_CUR])
    else $error("Overcurrent alarm while stopped.");

  no_line_a: assert property (
    cond_in.sync_needed && !cond_in.line_present |=> alarm_r[C_NO_LINE])
    else $error("No-line alarm missing.");

  stack_ol_a: assert property (
    stack_thermal_pct_in > STACK_OL_PCT |=> alarm_r[C_STACK_OL])
    else $error("Stack overload alarm missing.");

  di_disabled_a: assert property (
    (di_en_r == '0) [*3] |-> alarm_r[C_DI_BASE +: NUM_DI] == '0)
    else $error("Discrete alarm from disabled input.");

  analog_clear_a: assert property (
    !cond_in.analog_over |-> ##2 !alarm_r[C_ANALOG])
    else $error("Analog alarm stayed after condition cleared.");

  ph_loss_fault_c: cover property ($rose(fault_r[C_PH_LOSS]));
  start_promo_c: cover property (start_cmd_in && |(alarm_r & START_MASK));
  multi_alarm_c: cover property ($countones(alarm_r) >= 2);
  fault_clear_c: cover property ($fell(fault_r[C_ANALOG]));

endmodule

// ---- tb/mae_seq_model.sv ----
`timescale 1ns/1ns
module mae_seq_model
  import mae_pkg::*;
(
  input  wire logic      clock_in,
  input  wire logic      arst_n_in,
  input  wire mae_cond_t meas_in,
  input  wire logic      start_cmd_in,
  input  wire logic      fault_any_in,
  output mae_cond_t      cond_out
);
  logic running_r;
  logic running_nxt;
  // Any fault stops the motor, and it wins over a start in the same cycle.
  always_comb begin
    running_nxt = running_r;
    if (fault_any_in) begin
      running_nxt = 1'b0;
    end else if (start_cmd_in) begin
      running_nxt = 1'b1;
    end
  end
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      running_r <= 1'b0;
    end else begin
      running_r <= running_nxt;
    end
  end
  always_comb begin
    cond_out         = meas_in;
    cond_out.running = running_r;
  end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  import mae_pkg::*;
  logic              clk   = 1'b0;
  logic              rst_n = 1'b0;
  mae_cond_t         meas  = '0;
  mae_cond_t         cond;
  logic [PCT_W-1:0]  mot   = '0;
  logic [PCT_W-1:0]  stk   = '0;
  logic              olr   = 1'b0;
  logic              start = 1'b0;
  logic              wr    = 1'b0;
  logic              rd    = 1'b0;
  logic [NUM_DI-1:0] di    = '0;
  logic [ADDR_W-1:0] addr  = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic [CODE_W-1:0] alm;
  logic [CODE_W-1:0] flt;
  logic              any_a;
  logic              any_f;
  int                err_total  = 0;
  int                num_checks = 0;
  int                n;
  mae_seq_model mae_seq_model_i (.clock_in(clk), .arst_n_in(rst_n), .meas_in(meas), .start_cmd_in(start),
    .fault_any_in(any_f), .cond_out(cond));
  mae_alarm_top #(.TICK_CYC(4)) mae_alarm_top_i (.clock_in(clk), .arst_n_in(rst_n), .cond_in(cond),
    .motor_thermal_pct_in(mot), .stack_thermal_pct_in(stk), .ol_lockout_reset_in(olr), .start_cmd_in(start),
    .discrete_input_line_in(di), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .alarm_vec_out(alm), .fault_vec_out(flt), .alarm_any_out(any_a), .fault_any_out(any_f));
  initial forever #5 clk = ~clk;
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [CODE_W-1:0] seen, input logic [CODE_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Sampling lands 1 ns after the edge so that the design's updates have settled.
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wrr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", CODE_W'(rdata), CODE_W'(exp));
  endtask
  task automatic wait_flt(input int b);
    n = 0;
    while (flt[b] !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic pulse_start();
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    #1;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(REG_OL_LVL, 32'h0000005A);
    rdchk(REG_DELAY0, 32'h000003E8);
    rdchk(8'h3C, 32'h00000000);
    $display("test registers done");
    @(posedge clk) mot <= 8'h59;
    cyc(2);
    chk("alarm 2 low", alm[C_MOTOR_OL], 1'b0);
    @(posedge clk) mot <= 8'h5A;
    cyc(2);
    chk("alarm 2", alm[C_MOTOR_OL], 1'b1);
    @(posedge clk) mot <= 8'h64;
    cyc(2);
    chk("fault 2", flt[C_MOTOR_OL], 1'b1);
    @(posedge clk) mot <= 8'h10;
    cyc(3);
    chk("alarm 2 held", alm[C_MOTOR_OL], 1'b1);
    @(posedge clk) olr <= 1'b1;
    @(posedge clk) olr <= 1'b0;
    stk <= 8'h69;
    cyc(2);
    chk("alarm 2 reset", alm[C_MOTOR_OL], 1'b0);
    chk("alarm 47 at", alm[C_STACK_OL], 1'b0);
    @(posedge clk) stk <= 8'h6A;
    cyc(2);
    chk("alarm 47", alm[C_STACK_OL], 1'b1);
    $display("test thermal done");
    @(posedge clk) meas <= '{line_present: 1'b1, single_phase_seen: 1'b1, line_low: 3'h5, rtd_alarm: 3'h2,
      default: 1'b0};
    wrr(REG_CTRL, 32'h00000003);
    cyc(2);
    chk("alarms 10-15 cba", alm[15:10], 6'h22);
    chk("alarms 6-8", alm[8:6], 3'h2);
    wrr(REG_CTRL, 32'h00000000);
    meas.single_phase_seen <= 1'b0;
    cyc(2);
    chk("alarms 10-15 abc", alm[15:10], 6'h11);
    chk("alarms 21-26", alm[26:21], 6'h05);
    rdchk(REG_ALARM0, 32'h00A04480);
    pulse_start();
    chk("faults 10-15", flt[15:10], 6'h11);
    chk("faults 21-26", flt[26:21], 6'h05);
    $display("test start done");
    @(posedge clk) meas <= '0;
    stk <= 8'h00;
    for (int w = 0; w < NUM_WORDS; w++) wrr(REG_FAULT0 + ADDR_W'(w * 4), 32'hFFFFFFFF);
    wrr(8'h70, 32'h00000003);
    wrr(8'h4C, 32'h00000001);
    rdchk(REG_STATUS, 32'h00000000);
    @(posedge clk) meas.analog_over <= 1'b1;
    cyc(3);
    chk("alarm 71", alm[C_ANALOG], 1'b1);
    chk("alarm any", any_a, 1'b1);
    @(posedge clk) meas.analog_over <= 1'b0;
    cyc(3);
    chk("alarm 71 drop", {alm[C_ANALOG], flt[C_ANALOG]}, 2'h0);
    @(posedge clk) meas.analog_over <= 1'b1;
    wait_flt(C_ANALOG);
    chk("delay 71", n >= 8 && n < 300, 1'b1);
    cyc(2);
    chk("alarm 71 done", alm[C_ANALOG], 1'b0);
    rdchk(REG_FAULT0 + 8'h08, 32'h00000080);
    $display("test timed done");
    for (int w = 0; w < NUM_WORDS; w++) wrr(REG_FAULT0 + ADDR_W'(w * 4), 32'hFFFFFFFF);
    meas.analog_over <= 1'b0;
    meas.phase_loss  <= 1'b1;
    cyc(4);
    chk("alarm 27 stopped", alm[C_PH_LOSS], 1'b0);
    pulse_start();
    cyc(3);
    chk("alarm 27", alm[C_PH_LOSS], 1'b1);
    wait_flt(C_PH_LOSS);
    chk("fault 27", flt[C_PH_LOSS], 1'b1);
    chk("fault any", any_f, 1'b1);
    wrr(REG_CTRL, 32'h00000100);
    di <= 8'h03;
    {meas.freq_low, meas.sync_needed, meas.ride_wait, meas.ptc_hot, meas.tach_invalid} <= 5'h1F;
    cyc(6);
    chk("alarms 60-67", alm[67:60], 8'h01);
    chk("alarms 5 12", {alm[C_PTC], alm[C_FREQ_LO]}, 2'h3);
    chk("alarms 28 29 53", {alm[C_NO_LINE], alm[C_RIDE_TMO], alm[C_TACH]}, 3'h7);
    $display("test running done");
    test_done();
  end
  initial begin
    #100000;
    err_total++;
    test_done();
  end
endmodule
